// >>> design/rtc_csr_consts.svh
// Behaviour
// RQ1 - Update-pending reads 0 only when no update transfer starts within 244us.
// RQ2 - Update-pending is read-only, ignores reset pin; freeze blocks transfers, forces it 0.
// RQ3 - Oscillator field 010 keeps time; 11x holds the divider; other codes stop.
// RQ4 - First update comes 500ms after the run pattern is written.
// RQ5 - Rate field picks one of 13 taps or none, shared by wave and periodic flag.
// RQ6 - Rate bits are read/write and kept through the reset pin.
// RQ7 - Freeze 0 advances once per second; freeze 1 blocks transfers; only software changes it.
// RQ8 - Periodic enable gates the periodic flag onto the interrupt; reset pin clears it.
// RQ9 - Alarm fires each second three bytes match; 11xxxxxx matches anything; reset clears enable.
// RQ10 - Update-ended enable cleared by reset pin or by freeze going high.
// RQ11 - Square-wave pin toggles at selected rate when enabled, else held low; reset clears.
// RQ12 - Data-format bit selects binary or BCD; changed only by software.
// RQ13 - Hour-format bit selects 24 or 12 hour; read/write, kept through reset.
// RQ14 - Daylight saving: April first Sunday skips to 3:00, October last Sunday repeats 1:00.
// RQ15 - Summary flag is any flag-and-enable pair; while set, interrupt pin is low.
// RQ16 - Periodic flag is set on each selected tap edge, regardless of its enable.
// RQ17 - Alarm flag set on time match; with enable it asserts summary and pin.
// RQ18 - Update-ended flag set after each update cycle; with enable it asserts interrupt.
// RQ19 - Reading the flag register, or the reset pin, clears all flags.
// RQ20 - Low four bits of the flag register read 0 and ignore writes.
// RQ21 - Battery-valid bit is read-only, reset-proof; other seven bits read 0.
// RQ22 - Year 99 to 00 loads century with BCD 20, keeping its top bit.
// RQ23 - Flags stay stable while being read; events during a read post afterwards.
// RQ24 - Periodic rate spans 500ms slowest to 122us fastest.
// RQ25 - After a clearing read the pin releases unless a new enabled flag arrives.
`ifndef RTC_CSR_CONSTS_SVH
`define RTC_CSR_CONSTS_SVH

`define ADDR_OSC_RATE 8'h0A
`define ADDR_MODE 8'h0B
`define ADDR_FLAGS 8'h0C
`define ADDR_BATT 8'h0D
`define ADDR_CENTURY 8'h32

`define BIT_FREEZE 7
`define BIT_PIE 6
`define BIT_AIE 5
`define BIT_UIE 4
`define BIT_SQUARE_WAVE_ENABLE 3
`define BIT_DM 2
`define BIT_HR24 1
`define BIT_DSE 0

`define OSC_RUN 3'b010
`define OSC_RATE_RST 7'h00
`define MODE_RST 8'h00
`define CENTURY_RST 8'h20
`define CENTURY_LOAD 7'h20
`define ALARM_DONT_CARE 2'b11

`define CLK_HZ 200000000
`define OSC_HZ 32768
`define OSC_DIV_DEFAULT ((`CLK_HZ + `OSC_HZ / 2) / `OSC_HZ)
`define UIP_LEAD_US 244
`define UIP_LEAD_TICKS ((`UIP_LEAD_US * `OSC_HZ + 999999) / 1000000)
`define FIRST_UPDATE_MS 500
`define FIRST_UPDATE_TICKS (`FIRST_UPDATE_MS * `OSC_HZ / 1000)
`define CHAIN_TOP 32767

`endif

// >>> design/rtc_csr_pkg.sv
package rtc_csr_pkg;

    typedef struct packed {
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } hms_t;

    typedef struct packed {
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] weekday;
    } cal_t;

    typedef struct packed {
        logic pf;
        logic af;
        logic uf;
    } evt_t;

    typedef struct packed {
        logic as;
        logic ds;
        logic rw;
        logic cs_n;
        logic rst_n;
        logic batt;
    } pin_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_READ = 3'b010,
        BUS_WRITE = 3'b100
    } bus_state_t;

endpackage

// >>> design/rtc_control_status_regs.sv
`timescale 1ns/10ps
`include "rtc_csr_consts.svh"

module rtc_control_status_regs
    import rtc_csr_pkg::*;
#(
    parameter int OSC_DIV = `OSC_DIV_DEFAULT
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic as_pin,
    input wire logic ds_pin,
    input wire logic rw_pin,
    input wire logic cs_n,
    input wire logic reset_n,
    input wire logic battery_good,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic ad_oe_n,
    output logic irq_n,
    output logic square_wave_pin,
    input wire hms_t time_now,
    input wire hms_t alarm_time,
    input wire cal_t calendar,
    input wire logic year_rollover,
    output logic update_transfer,
    output logic data_format_binary,
    output logic hour_24,
    output logic dst_forward,
    output logic dst_back
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    pin_t pins_raw;
    pin_t pins_meta_r;
    pin_t pins_s_r;
    pin_t pins_prev_r;
    logic [7:0] ad_meta_r;
    logic [7:0] ad_s_r;

    assign pins_raw = '{as: as_pin, ds: ds_pin, rw: rw_pin, cs_n: cs_n,
                        rst_n: reset_n, batt: battery_good};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pins_meta_r <= '{as: 1'b0, ds: 1'b0, rw: 1'b1, cs_n: 1'b1, rst_n: 1'b1, batt: 1'b1};
            pins_s_r <= '{as: 1'b0, ds: 1'b0, rw: 1'b1, cs_n: 1'b1, rst_n: 1'b1, batt: 1'b1};
            pins_prev_r <= '{as: 1'b0, ds: 1'b0, rw: 1'b1, cs_n: 1'b1, rst_n: 1'b1, batt: 1'b1};
            ad_meta_r <= 8'h00;
            ad_s_r <= 8'h00;
        end else begin
            pins_meta_r <= pins_raw;
            pins_s_r <= pins_meta_r;
            pins_prev_r <= pins_s_r;
            ad_meta_r <= ad_in;
            ad_s_r <= ad_meta_r;
        end
    end

    logic as_fall;
    logic ds_rise;
    logic ds_fall;
    logic pin_reset;

    assign as_fall = pins_prev_r.as & ~pins_s_r.as;
    assign ds_rise = ~pins_prev_r.ds & pins_s_r.ds;
    assign ds_fall = pins_prev_r.ds & ~pins_s_r.ds;
    assign pin_reset = ~pins_s_r.rst_n;

    // ==========================================================
    // Multiplexed bus cycle
    // ==========================================================
    bus_state_t bus_r, bus_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [7:0] ad_out_r, ad_out_nxt;
    logic wr_stb;
    logic flags_read_done;
    logic [7:0] rd_mux;

    always_comb begin
        bus_nxt = bus_r;
        addr_nxt = addr_r;
        ad_out_nxt = 8'h00;
        wr_stb = 1'b0;
        flags_read_done = 1'b0;
        if (as_fall) begin
            addr_nxt = ad_s_r;
        end
        unique case (bus_r)
            BUS_IDLE: begin
                if (ds_rise && !pins_s_r.cs_n) begin
                    bus_nxt = pins_s_r.rw ? BUS_READ : BUS_WRITE;
                    ad_out_nxt = rd_mux;
                end
            end
            BUS_READ: begin
                ad_out_nxt = rd_mux;
                if (ds_fall) begin
                    bus_nxt = BUS_IDLE;
                    flags_read_done = (addr_r == `ADDR_FLAGS); // RQ19
                end
            end
            BUS_WRITE: begin
                if (ds_fall) begin
                    bus_nxt = BUS_IDLE;
                    wr_stb = 1'b1;
                end
            end
            default: begin
                bus_nxt = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_r <= BUS_IDLE;
            addr_r <= 8'h00;
            ad_out_r <= 8'h00;
        end else begin
            bus_r <= bus_nxt;
            addr_r <= addr_nxt;
            ad_out_r <= ad_out_nxt;
        end
    end

    assign ad_out = ad_out_r;
    assign ad_oe_n = (bus_r != BUS_READ);

    // ==========================================================
    // Oscillator tick and 15-stage divider chain
    // ==========================================================
    logic [12:0] osc_cnt_r, osc_cnt_nxt;
    logic [14:0] chain_r, chain_nxt;
    logic osc_tick;
    logic [6:0] osc_rate_r;
    logic [7:0] mode_r;
    logic chain_run;
    logic update_cycle;
    logic update_pending;

    assign osc_tick = (osc_cnt_r == 13'(OSC_DIV - 1));
    assign chain_run = (osc_rate_r[6:4] == `OSC_RUN); // RQ3

    always_comb begin
        osc_cnt_nxt = osc_tick ? 13'h0000 : osc_cnt_r + 13'h0001;
        // Held chain parks half a second short of the rollover
        chain_nxt = 15'(`CHAIN_TOP + 1 - `FIRST_UPDATE_TICKS); // RQ4
        if (chain_run) begin
            chain_nxt = osc_tick ? chain_r + 15'h0001 : chain_r;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            osc_cnt_r <= 13'h0000;
            chain_r <= 15'(`CHAIN_TOP + 1 - `FIRST_UPDATE_TICKS);
        end else begin
            osc_cnt_r <= osc_cnt_nxt;
            chain_r <= chain_nxt;
        end
    end

    // Internal count advances every second even while frozen
    assign update_cycle = chain_run && osc_tick && (chain_r == 15'(`CHAIN_TOP)); // RQ7
    // One tick of margin so a zero read always leaves the full lead time
    assign update_pending = chain_run && !mode_r[`BIT_FREEZE] &&
        (chain_r >= 15'(`CHAIN_TOP - `UIP_LEAD_TICKS)); // RQ1 RQ2

    // ==========================================================
    // Rate tap selection
    // ==========================================================
    logic [3:0] rate_sel;
    logic [3:0] tap_idx;
    logic tap_bit;
    logic tap_prev_r;
    logic sqw_r, sqw_nxt;
    logic pf_event;

    assign rate_sel = osc_rate_r[3:0];

    always_comb begin
        // Codes 1 and 2 repeat the 256 Hz and 128 Hz taps
        unique case (rate_sel)
            4'h1: tap_idx = 4'h6;
            4'h2: tap_idx = 4'h7;
            default: tap_idx = rate_sel - 4'h2; // RQ5 RQ24
        endcase
        tap_bit = (rate_sel != 4'h0) && chain_r[tap_idx];
        sqw_nxt = mode_r[`BIT_SQUARE_WAVE_ENABLE] && tap_bit; // RQ11
    end

    assign pf_event = tap_bit && !tap_prev_r; // RQ16

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tap_prev_r <= 1'b0;
            sqw_r <= 1'b0;
        end else begin
            tap_prev_r <= tap_bit;
            sqw_r <= sqw_nxt;
        end
    end

    assign square_wave_pin = sqw_r;

    // ==========================================================
    // Control registers and century
    // ==========================================================
    logic [6:0] osc_rate_nxt;
    logic [7:0] mode_nxt;
    logic [7:0] century_r, century_nxt;

    always_comb begin
        osc_rate_nxt = osc_rate_r;
        mode_nxt = mode_r;
        century_nxt = century_r;
        if (wr_stb && addr_r == `ADDR_OSC_RATE) begin
            osc_rate_nxt = ad_s_r[6:0]; // RQ3 RQ6
        end
        if (wr_stb && addr_r == `ADDR_MODE) begin
            mode_nxt = ad_s_r; // RQ12 RQ13
            if (ad_s_r[`BIT_FREEZE] && !mode_r[`BIT_FREEZE]) begin
                mode_nxt[`BIT_UIE] = 1'b0; // RQ10
            end
        end
        if (year_rollover) begin
            century_nxt = {century_r[7], `CENTURY_LOAD}; // RQ22
        end
        if (wr_stb && addr_r == `ADDR_CENTURY) begin
            century_nxt = ad_s_r;
        end
        if (pin_reset) begin
            mode_nxt[`BIT_PIE] = 1'b0; // RQ8
            mode_nxt[`BIT_AIE] = 1'b0; // RQ9
            mode_nxt[`BIT_UIE] = 1'b0; // RQ10
            mode_nxt[`BIT_SQUARE_WAVE_ENABLE] = 1'b0; // RQ11
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            osc_rate_r <= `OSC_RATE_RST;
            mode_r <= `MODE_RST;
            century_r <= `CENTURY_RST;
        end else begin
            osc_rate_r <= osc_rate_nxt;
            mode_r <= mode_nxt;
            century_r <= century_nxt;
        end
    end

    assign data_format_binary = mode_r[`BIT_DM];
    assign hour_24 = mode_r[`BIT_HR24];

    // ==========================================================
    // Alarm match
    // ==========================================================
    logic [2:0] byte_hit;
    logic af_event;

    for (genvar i = 0; i < 3; i++) begin : g_alarm
        assign byte_hit[i] = (alarm_time[8*i+6 +: 2] == `ALARM_DONT_CARE) ||
            (alarm_time[8*i +: 8] == time_now[8*i +: 8]); // RQ9
    end

    assign af_event = update_cycle && (&byte_hit); // RQ17

    // ==========================================================
    // Event flags and interrupt
    // ==========================================================
    evt_t flags_r, flags_nxt;
    evt_t pend_r, pend_nxt;
    evt_t events;
    logic flags_busy;
    logic irq_summary_flag;
    logic irq_n_r;

    assign events = '{pf: pf_event, af: af_event, uf: update_cycle}; // RQ18
    assign flags_busy = (bus_r == BUS_READ) && (addr_r == `ADDR_FLAGS);

    always_comb begin
        flags_nxt = flags_r;
        pend_nxt = pend_r;
        if (pin_reset) begin
            flags_nxt = '0; // RQ19
            pend_nxt = '0;
        end else if (flags_busy) begin
            // Hold flags steady for the reader; park new events
            pend_nxt = pend_r | events; // RQ23
            if (flags_read_done) begin
                flags_nxt = pend_r | events; // RQ19 RQ23
                pend_nxt = '0;
            end
        end else begin
            flags_nxt = flags_r | pend_r | events;
            pend_nxt = '0;
        end
    end

    assign irq_summary_flag = (flags_r.pf && mode_r[`BIT_PIE]) ||
        (flags_r.af && mode_r[`BIT_AIE]) ||
        (flags_r.uf && mode_r[`BIT_UIE]); // RQ15 RQ17 RQ18

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_r <= '0;
            pend_r <= '0;
            irq_n_r <= 1'b1;
        end else begin
            flags_r <= flags_nxt;
            pend_r <= pend_nxt;
            irq_n_r <= !irq_summary_flag; // RQ15 RQ25
        end
    end

    assign irq_n = irq_n_r;

    // ==========================================================
    // Read data
    // ==========================================================
    always_comb begin
        unique case (addr_r)
            `ADDR_OSC_RATE: rd_mux = {update_pending, osc_rate_r}; // RQ2 RQ6
            `ADDR_MODE: rd_mux = mode_r;
            `ADDR_FLAGS: rd_mux = {irq_summary_flag, flags_r, 4'h0}; // RQ20
            `ADDR_BATT: rd_mux = {pins_s_r.batt, 7'h00}; // RQ21
            `ADDR_CENTURY: rd_mux = century_r;
            default: rd_mux = 8'h00;
        endcase
    end

    // ==========================================================
    // Update transfer and daylight saving
    // ==========================================================
    logic xfer_r, xfer_nxt;
    logic fwd_day_r, fwd_day_nxt;
    logic back_day_r, back_day_nxt;
    logic fwd_r, fwd_nxt;
    logic back_r, back_nxt;
    logic at_midnight;
    logic at_two;
    logic is_sunday;
    logic april_first;
    logic october_last;

    always_comb begin
        at_midnight = (time_now.second == 8'h00) && (time_now.minute == 8'h00) &&
            (mode_r[`BIT_HR24] ? (time_now.hour == 8'h00) :
             (time_now.hour == (mode_r[`BIT_DM] ? 8'h0C : 8'h12)));
        at_two = (time_now.second == 8'h00) && (time_now.minute == 8'h00) &&
            (time_now.hour == 8'h02);
        is_sunday = (calendar.weekday == 8'h01);
        april_first = is_sunday && (calendar.month == 8'h04) && (calendar.date <= 8'h07);
        october_last = is_sunday &&
            (calendar.month == (mode_r[`BIT_DM] ? 8'h0A : 8'h10)) &&
            (calendar.date >= (mode_r[`BIT_DM] ? 8'h19 : 8'h25));
        xfer_nxt = update_cycle && !mode_r[`BIT_FREEZE]; // RQ2 RQ7
        fwd_day_nxt = fwd_day_r;
        back_day_nxt = back_day_r;
        fwd_nxt = 1'b0;
        back_nxt = 1'b0;
        if (update_cycle && at_midnight) begin
            // Sunday test happens only here
            fwd_day_nxt = mode_r[`BIT_DSE] && april_first; // RQ14
            back_day_nxt = mode_r[`BIT_DSE] && october_last; // RQ14
        end else if (update_cycle && at_two && mode_r[`BIT_DSE]) begin
            fwd_nxt = fwd_day_r; // RQ14
            back_nxt = back_day_r;
            // Repeat the hour only once
            back_day_nxt = 1'b0; // RQ14
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            xfer_r <= 1'b0;
            fwd_day_r <= 1'b0;
            back_day_r <= 1'b0;
            fwd_r <= 1'b0;
            back_r <= 1'b0;
        end else begin
            xfer_r <= xfer_nxt;
            fwd_day_r <= fwd_day_nxt;
            back_day_r <= back_day_nxt;
            fwd_r <= fwd_nxt;
            back_r <= back_nxt;
        end
    end

    assign update_transfer = xfer_r;
    assign dst_forward = fwd_r;
    assign dst_back = back_r;

endmodule

// >>> tb/rtc_host_model.sv
`timescale 1ns/10ps
module rtc_host_model (
    input wire logic clk,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe_n,
    output logic as_pin,
    output logic ds_pin,
    output logic rw_pin,
    output logic cs_n,
    output logic [7:0] ad_in
);
    logic h_oe = 1'b0;
    logic [7:0] h_val = 8'h00;
    initial begin
        as_pin = 1'b0;
        ds_pin = 1'b0;
        rw_pin = 1'b1;
        cs_n = 1'b1;
    end
    // Released bus shows the inverse of the last value, never a kind zero
    assign ad_in = !ad_oe_n ? ad_out : (h_oe ? h_val : ~h_val);

    // ====================
    // One byte cycle; each phase held well past the device's input sync
    task automatic cycle(input logic rd, input logic sel, input logic [7:0] a,
                         input logic [7:0] wd, output logic [7:0] q);
        @(negedge clk);
        as_pin <= 1'b1;
        h_oe <= 1'b1;
        h_val <= a;
        rw_pin <= rd;
        cs_n <= !sel;
        repeat (4) @(negedge clk);
        as_pin <= 1'b0;
        repeat (4) @(negedge clk);
        h_oe <= !rd;
        h_val <= rd ? a : wd;
        ds_pin <= 1'b1;
        repeat (8) @(negedge clk);
        q = ad_in;
        ds_pin <= 1'b0;
        repeat (4) @(negedge clk);
        h_oe <= 1'b0;
        cs_n <= 1'b1;
        repeat (4) @(negedge clk);
    endtask
endmodule

// >>> tb/rtc_csr_chk_sva.sv
`timescale 1ns/10ps
module rtc_csr_chk #(
    parameter int OSC_DIV = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic as_pin,
    input wire logic ds_pin,
    input wire logic rw_pin,
    input wire logic cs_n,
    input wire logic battery_good,
    input wire logic [7:0] ad_in,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe_n,
    input wire logic irq_n,
    input wire logic update_transfer
);
    // ====================
    // Address latch mirrored from the pins
    logic as_r, as_nxt, mapped;
    logic [7:0] addr_r, addr_nxt;
    always_comb begin
        as_nxt = as_pin;
        addr_nxt = (as_r && !as_pin) ? ad_in : addr_r;
        mapped = addr_r inside {8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h32};
    end
    always_ff @(posedge clk) begin
        as_r <= as_nxt;
        addr_r <= addr_nxt;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ====================
    // Properties
    chk_read_drive: assert property ($rose(ds_pin) && !cs_n && rw_pin |-> ##[1:5] !ad_oe_n)
        else $error("read not answered");
    chk_drive_cause: assert property ($fell(ad_oe_n) |-> $past(ds_pin, 2) && $past(rw_pin, 2))
        else $error("bus driven without a read");
    chk_drive_end: assert property ($fell(ds_pin) && !ad_oe_n |-> ##[1:5] ad_oe_n)
        else $error("bus not released");
    chk_write_quiet: assert property ($rose(ds_pin) && !rw_pin |-> ad_oe_n [*8])
        else $error("bus driven in a write");
    chk_cs_refused: assert property ($rose(ds_pin) && cs_n |-> ad_oe_n [*8])
        else $error("bus driven while deselected");
    chk_flags_low: assert property ($fell(ad_oe_n) && addr_r == 8'h0C |-> ##1 ad_out[3:0] == 4'h0)
        else $error("flag low nibble not zero");
    chk_batt_read: assert property ($fell(ad_oe_n) && addr_r == 8'h0D |->
        ##1 ad_out == {battery_good, 7'h00})
        else $error("battery byte wrong");
    chk_unmapped_zero: assert property ($fell(ad_oe_n) && !mapped |-> ##1 ad_out == 8'h00)
        else $error("unmapped read not zero");
    chk_flags_stable: assert property (addr_r == 8'h0C && !ad_oe_n && !$past(ad_oe_n)
        && !$past(ad_oe_n, 2) |-> $stable(ad_out))
        else $error("flag byte moved during read");
    chk_irq_release: assert property ($rose(ad_oe_n) && addr_r == 8'h0C |-> ##[1:2] irq_n)
        else $error("interrupt held after flag read");
    chk_update_once: assert property (update_transfer |=> !update_transfer [*8])
        else $error("update repeated");

    cov_flag_read: cover property ($rose(ad_oe_n) && addr_r == 8'h0C);
    cov_update: cover property (update_transfer);
    cov_irq: cover property ($fell(irq_n));
endmodule

bind rtc_control_status_regs rtc_csr_chk #(.OSC_DIV(OSC_DIV)) chk_i (
    .clk(clk), .sys_rst(sys_rst), .as_pin(as_pin), .ds_pin(ds_pin), .rw_pin(rw_pin),
    .cs_n(cs_n), .battery_good(battery_good), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe_n(ad_oe_n), .irq_n(irq_n), .update_transfer(update_transfer)
);

// >>> tb/rtc_control_status_regs_test.sv
`timescale 1ns/10ps
module rtc_control_status_regs_test;
    import rtc_csr_pkg::*;
    // One tick per clock so two updates fit in the run
    localparam int OSC_DIV = 1;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reset_n = 1'b1;
    logic battery_good = 1'b1;
    logic year_rollover = 1'b0;
    hms_t time_now = 24'h120000;
    hms_t alarm_time = 24'hC50000;
    cal_t calendar = 24'h040301;
    logic as_pin, ds_pin, rw_pin, cs_n, ad_oe_n, irq_n, square_wave_pin;
    logic update_transfer, data_format_binary, hour_24, dst_forward, dst_back;
    logic [7:0] ad_in, ad_out;
    logic [31:0] r;
    int err_count = 0;
    int samples_checked = 0;
    int m_osc = 0;
    int m_mode = 0;
    int m_cent = 'h20;
    int m_flags = 0;
    int edges, cnt;
    int addr_list[$] = '{'h0A, 'h0B, 'h0C, 'h0D, 'h32, 'h40};

    always #2.5 clk = ~clk;

    rtc_control_status_regs #(.OSC_DIV(OSC_DIV)) uut (
        .clk(clk), .sys_rst(sys_rst), .as_pin(as_pin), .ds_pin(ds_pin), .rw_pin(rw_pin),
        .cs_n(cs_n), .reset_n(reset_n), .battery_good(battery_good), .ad_in(ad_in),
        .ad_out(ad_out), .ad_oe_n(ad_oe_n), .irq_n(irq_n), .square_wave_pin(square_wave_pin),
        .time_now(time_now), .alarm_time(alarm_time), .calendar(calendar),
        .year_rollover(year_rollover), .update_transfer(update_transfer),
        .data_format_binary(data_format_binary), .hour_24(hour_24),
        .dst_forward(dst_forward), .dst_back(dst_back)
    );
    rtc_host_model host (
        .clk(clk), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .as_pin(as_pin), .ds_pin(ds_pin),
        .rw_pin(rw_pin), .cs_n(cs_n), .ad_in(ad_in)
    );

    // ====================
    // Reference register model and helpers
    function automatic logic [7:0] expv(input int a);
        case (a)
            'h0A: return 8'(m_osc);
            'h0B: return 8'(m_mode);
            'h0C: return 8'(m_flags);
            'h0D: return {battery_good, 7'h00};
            'h32: return 8'(m_cent);
            default: return 8'h00;
        endcase
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
        logic [7:0] q;
        host.cycle(1'b1, 1'b1, a, 8'h00, q);
        check(q & msk, exp & msk);
        if (a == 8'h0C) m_flags = 0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic sel);
        logic [7:0] q;
        host.cycle(1'b0, sel, a, d, q);
        if (sel && a == 8'h0A) m_osc = d & 8'h7F;
        if (sel && a == 8'h0B) m_mode = (!m_mode[7] && d[7]) ? (d & 8'hEF) : d;
        if (sel && a == 8'h32) m_cent = d;
    endtask

    task automatic scan();
        foreach (addr_list[i]) rd(8'(addr_list[i]), expv(addr_list[i]), 8'hFF);
    endtask

    task automatic count_edges(input int n, output int c);
        logic prev;
        c = 0;
        prev = square_wave_pin;
        repeat (n) begin
            @(negedge clk);
            if (square_wave_pin && !prev) c++;
            prev = square_wave_pin;
        end
    endtask

    task automatic results();
        $display("errors=%0d checks=%0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        err_count++;
        results();
    end

    // ====================
    // Main sequence
    initial begin
        void'($urandom(32'h9072));
        repeat (5) @(negedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(negedge clk);
        scan();
        wr(8'h0C, 8'hFF, 1'b1);
        wr(8'h0D, 8'hFF, 1'b1);
        wr(8'h32, 8'h55, 1'b0);
        host.cycle(1'b1, 1'b0, 8'h0B, 8'h00, r[7:0]);
        check(r[7:0], 8'hF4);
        battery_good <= 1'b0;
        scan();
        battery_good <= 1'b1;
        // Chain kept stopped or held here, so no flag can rise
        repeat (4) begin
            r = $urandom;
            wr(8'h0A, {r[7], 1'b1, r[5:0]}, 1'b1);
            wr(8'h0B, r[15:8], 1'b1);
            wr(8'h32, r[23:16], 1'b1);
            check({6'h0, data_format_binary, hour_24}, {6'h0, m_mode[2], m_mode[1]});
            scan();
        end
        wr(8'h0B, 8'h7F, 1'b1);
        reset_n <= 1'b0;
        repeat (8) @(negedge clk);
        reset_n <= 1'b1;
        repeat (4) @(negedge clk);
        m_mode = m_mode & 'h87;
        scan();
        wr(8'h0B, 8'h10, 1'b1);
        wr(8'h0B, 8'h90, 1'b1);
        rd(8'h0B, 8'(m_mode), 8'hFF);
        // Fastest tap, then no tap
        wr(8'h0B, 8'h00, 1'b1);
        wr(8'h0A, 8'h23, 1'b1);
        count_edges(64, edges);
        check(8'(edges), 8'h00);
        rd(8'h0C, 8'h40, 8'hC0);
        check({7'h0, irq_n}, 8'h01);
        wr(8'h0B, 8'h48, 1'b1);
        check({7'h0, irq_n}, 8'h00);
        count_edges(16, edges);
        check({7'h0, edges inside {[3:5]}}, 8'h01);
        wr(8'h0B, 8'h08, 1'b1);
        wr(8'h0A, 8'h20, 1'b1);
        rd(8'h0C, 8'h40, 8'h40);
        count_edges(200, edges);
        check(8'(edges), 8'h00);
        rd(8'h0C, 8'h00, 8'hFF);
        wr(8'h32, 8'h99, 1'b1);
        year_rollover <= 1'b1;
        @(negedge clk);
        year_rollover <= 1'b0;
        m_cent = (m_cent & 'h80) | 'h20;
        rd(8'h32, 8'(m_cent), 8'hFF);
        // Held chain restarts half a second before the first update
        wr(8'h0B, 8'h31, 1'b1);
        wr(8'h0A, 8'h60, 1'b1);
        wr(8'h0A, 8'h20, 1'b1);
        cnt = 0;
        while (update_transfer !== 1'b1 && cnt < 20000) begin
            @(negedge clk);
            cnt++;
        end
        check({7'h0, cnt inside {[16360:16400]}}, 8'h01);
        check({6'h0, dst_forward, dst_back}, 8'h00);
        repeat (3) @(negedge clk);
        check({7'h0, irq_n}, 8'h00);
        m_flags = 'hB0;
        rd(8'h0C, 8'(m_flags), 8'hFF);
        check({7'h0, irq_n}, 8'h01);
        rd(8'h0C, 8'h00, 8'hFF);
        // Midnight test armed the April Sunday; 2:00 must jump forward
        time_now <= 24'h020000;
        cnt = 0;
        while (update_transfer !== 1'b1 && cnt < 40000) begin
            @(negedge clk);
            cnt++;
        end
        check({7'h0, cnt inside {[32690:32740]}}, 8'h01);
        check({6'h0, dst_forward, dst_back}, 8'h02);
        results();
    end
endmodule
